// ### tapdec_ir.sv
// instruction shifter and latched instruction register on the test clock
`timescale 1ns/10ps
`default_nettype none
module tapdec_ir (
  // test clock and asynchronous tap reset
  input  wire logic                 i_tck,
  input  wire logic                 i_trst,
  // tap controller states
  input  wire logic                 i_tlr,
  input  wire logic                 i_capture_ir,
  input  wire logic                 i_shift_ir,
  input  wire logic                 i_update_ir,
  // serial data
  input  wire logic                 i_tdi,
  output logic                      o_ir_lsb,
  output tapdec_pkg::tapdec_op_t    o_ir
);

  tapdec_pkg::tapdec_op_t shifter;
  tapdec_pkg::tapdec_op_t next_shifter;
  tapdec_pkg::tapdec_op_t ir;
  tapdec_pkg::tapdec_op_t next_ir;

  always_comb
  begin
    next_shifter = shifter;
    if (i_capture_ir)
    begin
      next_shifter = tapdec_pkg::IR_CAPTURE_PAT; // R18
    end
    else if (i_shift_ir)
    begin
      next_shifter = {i_tdi, shifter[tapdec_pkg::IR_W-1:1]};
    end
  end

  always_ff @(posedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      shifter <= tapdec_pkg::IR_CAPTURE_PAT;
    else
      shifter <= next_shifter;
  end

  // instruction changes only on update or test-logic-reset, on the falling edge
  always_comb
  begin
    next_ir = ir;
    if (i_tlr)
    begin
      next_ir = tapdec_pkg::IR_RESET_VAL; // R19
    end
    else if (i_update_ir)
    begin
      next_ir = shifter; // R17
    end
  end

  always_ff @(negedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      ir <= tapdec_pkg::IR_RESET_VAL; // R19
    else
      ir <= next_ir;
  end

  assign o_ir     = ir;
  assign o_ir_lsb = shifter[0];

  a_capture_pattern: assert property (@(posedge i_tck) disable iff (i_trst) // R18
    i_capture_ir |=> shifter == tapdec_pkg::IR_CAPTURE_PAT)
    else $error("capture did not load the fixed pattern");
  a_ir_holds: assert property (@(negedge i_tck) disable iff (i_trst) // R17
    !i_update_ir && !i_tlr |=> $stable(ir))
    else $error("instruction changed outside update");
  a_tlr_idcode: assert property (@(negedge i_tck) disable iff (i_trst) // R19
    i_tlr |=> ir == tapdec_pkg::OP_IDCODE)
    else $error("test-logic-reset did not load identification code");

endmodule
`default_nettype wire

// ### tapdec_master.sv
// behavioural tap master: test clock, tap state levels and serial data
`timescale 1ns/10ps
`default_nettype none
module tapdec_master (
  // test clock and state levels {tlr,cap_ir,shift_ir,upd_ir,cap_dr,shift_dr}
  output logic       o_tck,
  output logic [5:0] o_st,
  output logic       o_tdi,
  // serial return
  input  wire logic  i_tdo,
  input  wire logic  i_tdo_oe
);
  logic        oe_all;
  logic [31:0] lf;

  initial
  begin
    o_tck = 1'b1;
    o_st = '0;
    o_tdi = 1'b0;
    oe_all = 1'b1;
    lf = 32'h0000_0001;
  end

  // one tap state a call; tck only runs here, so it stands still between frames
  task automatic cyc(input logic [5:0] st, input logic d, output logic so);
    o_st = st;
    o_tdi = d;
    #6.5 o_tck = 1'b0;
    #7.5 so = i_tdo;
    if (st[3] || st[0])
      oe_all = oe_all & i_tdo_oe;
    o_tck = 1'b1;
    #1;
  endtask

  // idle tdi follows a 32-bit lfsr so a stale level never passes for data
  task automatic idle(input int n);
    logic s;
    repeat (n)
    begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      cyc(6'h00, lf[0], s);
    end
  endtask

  task automatic load_ir(input logic [5:0] op, input logic upd, output logic [5:0] cap);
    logic s;
    cyc(6'h10, 1'b0, s);
    for (int i = 0; i < 6; i++)
      cyc(6'h08, op[i], cap[i]);
    cyc(upd ? 6'h04 : 6'h00, 1'b0, s);
    idle(6);
  endtask

  task automatic scan_dr(input logic [7:0] din, output logic [7:0] dout);
    logic s;
    cyc(6'h02, 1'b0, s);
    for (int i = 0; i < 8; i++)
      cyc(6'h01, din[i], dout[i]);
    idle(6);
  endtask

  task automatic reset_tap();
    logic s;
    cyc(6'h20, 1'b0, s);
    idle(6);
  endtask
endmodule
`default_nettype wire

// ### tapdec_pkg.sv
// package: opcodes, selects and decode for the tap instruction decoder
`default_nettype none
package tapdec_pkg;

  localparam int unsigned IR_W = 6;

  typedef logic [IR_W-1:0] tapdec_op_t;

  // opcodes
  localparam tapdec_op_t OP_IDCODE     = 6'h01;
  localparam tapdec_op_t OP_SAMPLE_PRE = 6'h02;
  localparam tapdec_op_t OP_SAMPLE     = 6'h03;
  localparam tapdec_op_t OP_EXTEST     = 6'h04;
  localparam tapdec_op_t OP_FDBG_A     = 6'h05;
  localparam tapdec_op_t OP_FDBG_B     = 6'h06;
  localparam tapdec_op_t OP_UNLOCK_KEY = 6'h07;
  localparam tapdec_op_t OP_HIGHZ      = 6'h09;
  localparam tapdec_op_t OP_FDBG_C     = 6'h0a;
  localparam tapdec_op_t OP_CLAMP      = 6'h0c;
  localparam tapdec_op_t OP_IFACE_CTRL = 6'h0e;
  localparam tapdec_op_t OP_IFACE_PAD  = 6'h0f;
  localparam tapdec_op_t OP_AUX_LO     = 6'h20;
  localparam tapdec_op_t OP_AUX_TRACE  = 6'h21;
  localparam tapdec_op_t OP_AUX_RSV    = 6'h22;
  localparam tapdec_op_t OP_AUX_FTEST  = 6'h25;
  localparam tapdec_op_t OP_AUX_SECDBG = 6'h26;
  localparam tapdec_op_t OP_AUX_SECCORE = 6'h27;
  localparam tapdec_op_t OP_AUX_CORE0  = 6'h28;
  localparam tapdec_op_t OP_AUX_CORE1  = 6'h29;
  localparam tapdec_op_t OP_AUX_HI     = 6'h3e;

  // reset and capture values
  localparam tapdec_op_t IR_RESET_VAL   = 6'h01;
  localparam tapdec_op_t IR_CAPTURE_PAT = 6'h01;

  typedef enum logic [2:0] {
    DR_BYPASS,
    DR_IDCODE,
    DR_BSR,
    DR_UNLOCK_KEY,
    DR_IFACE_CTRL,
    DR_IFACE_PAD,
    DR_AUX
  } tapdec_dr_e;

  typedef struct packed {
    tapdec_dr_e  dr;
    logic        aux_grant;
    logic [4:0]  aux_port;
  } tapdec_sel_s;

  typedef struct packed {
    logic func_reset;
    logic pins_highz;
    logic drive_preload;
  } tapdec_fx_s;

  // reserved, factory and undefined codes all fall to bypass
  function automatic tapdec_sel_s decode_sel(input tapdec_op_t op);
    tapdec_sel_s s;
    s = '{dr: DR_BYPASS, aux_grant: 1'b0, aux_port: op[4:0]};
    case (op)
      OP_IDCODE:     s.dr = DR_IDCODE; // R1
      OP_SAMPLE_PRE, // R2
      OP_SAMPLE, // R3
      OP_EXTEST:     s.dr = DR_BSR; // R4
      OP_UNLOCK_KEY: s.dr = DR_UNLOCK_KEY; // R5
      OP_IFACE_CTRL: s.dr = DR_IFACE_CTRL; // R8
      OP_IFACE_PAD:  s.dr = DR_IFACE_PAD; // R9
      OP_AUX_TRACE, // R12
      OP_AUX_SECDBG, // R13
      OP_AUX_SECCORE, // R14
      OP_AUX_CORE0,
      OP_AUX_CORE1: // R10 R15
      begin
        s.dr        = DR_AUX;
        s.aux_grant = 1'b1;
      end
      default:       s.dr = DR_BYPASS; // R6 R7 R11 R16 R21
    endcase
    return s;
  endfunction

  function automatic tapdec_fx_s decode_fx(input tapdec_op_t op);
    tapdec_fx_s f;
    f = '0;
    case (op)
      OP_EXTEST: f = '{func_reset: 1'b1, pins_highz: 1'b0, drive_preload: 1'b1}; // R4
      OP_HIGHZ:  f = '{func_reset: 1'b1, pins_highz: 1'b1, drive_preload: 1'b0}; // R6
      OP_CLAMP:  f = '{func_reset: 1'b1, pins_highz: 1'b0, drive_preload: 1'b1}; // R7
      default:   f = '0;
    endcase
    return f;
  endfunction

endpackage
`default_nettype wire

// ### tapdec_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module tapdec_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // level in and out
  input  wire logic i_d,
  output logic      o_q
);

  typedef struct packed {
    logic meta;
    logic q;
  } tapdec_sync_s;

  tapdec_sync_s st;
  tapdec_sync_s next_st;

  always_comb
  begin
    next_st.meta = i_d;
    next_st.q    = st.meta;
    if (i_rst)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    st <= next_st;
  end

  assign o_q = st.q;

endmodule
`default_nettype wire

// ### tapdec_top.sv
// tap instruction decode: serial path select, aux handoff and pin effects
`timescale 1ns/10ps
`default_nettype none
// Contract
// (R1) code 000001 puts the identification register in the serial path.
// (R2) code 000010 selects boundary scan for sample and preload, no functional effect.
// (R3) code 000011 selects boundary scan for sampling only, no functional effect.
// (R4) code 000100 selects boundary scan, drives preloaded pins, holds functional reset.
// (R5) code 000111 selects the debug unlock key register.
// (R6) code 001001 selects bypass, floats all outputs, holds functional reset.
// (R7) code 001100 selects bypass, drives preloaded pins, holds functional reset.
// (R8) code 001110 opens the debug interface control register.
// (R9) code 001111 opens the debug interface pad control register.
// (R10) codes 100000 to 111110 hand the port to one aux controller by code; decode grants only 100001, 100110, 100111, 101000 and 101001.
// (R11) codes 000101, 000110, 001010 are factory debug, no customer function.
// (R12) code 100001 hands the port to the trace aux controller.
// (R13) code 100110 hands the port to the secure debug controller.
// (R14) code 100111 hands the port to the security core controller.
// (R15) codes 101000 and 101001 hand the port to core 0 and core 1.
// (R16) codes 100101, 100000, 100010 are reserved, no customer function.
// (R17) six-bit instruction takes effect only when latched in update.
// (R18) capture loads 000001 into the instruction shifter.
// (R19) test-logic-reset, synchronous or asynchronous, loads the identification code.
// (R20) the master loads no undefined codes.
// (R21) reserved or undefined codes put the one-bit bypass in the path.
module tapdec_top (
  // system clock and synchronous reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // test clock and asynchronous tap reset
  input  wire logic                   i_tck,
  input  wire logic                   i_trst,
  // tap controller states, test clock domain
  input  wire logic                   i_tlr,
  input  wire logic                   i_capture_ir,
  input  wire logic                   i_shift_ir,
  input  wire logic                   i_update_ir,
  input  wire logic                   i_capture_dr,
  input  wire logic                   i_shift_dr,
  // serial in and data register serial outs
  input  wire logic                   i_tdi,
  input  wire logic                   i_tdo_idcode,
  input  wire logic                   i_tdo_bsr,
  input  wire logic                   i_tdo_unlock_key,
  input  wire logic                   i_tdo_iface_ctrl,
  input  wire logic                   i_tdo_iface_pad,
  input  wire logic                   i_tdo_aux,
  // serial out, test clock domain
  output logic                        o_tdo,
  output logic                        o_tdo_oe,
  // data register selects and aux handoff, test clock domain
  output tapdec_pkg::tapdec_sel_s     o_sel,
  output tapdec_pkg::tapdec_op_t      o_ir,
  // functional effects, system clock domain
  output tapdec_pkg::tapdec_fx_s      o_fx,
  output tapdec_pkg::tapdec_op_t      o_active_op
);

  // falling-edge state of the test clock domain
  typedef struct packed {
    tapdec_pkg::tapdec_sel_s sel;
    logic                    tdo;
    logic                    tdo_oe;
  } tapdec_neg_s;

  // rising-edge state of the test clock domain
  typedef struct packed {
    logic                    bypass;
    tapdec_pkg::tapdec_op_t  xfer;
    logic                    req;
  } tapdec_pos_s;

  // system clock domain state
  typedef struct packed {
    tapdec_pkg::tapdec_op_t  op;
    logic                    ack;
    tapdec_pkg::tapdec_fx_s  fx;
  } tapdec_sys_s;

  localparam tapdec_neg_s NEG_RESET = '{
    sel:    '{dr: tapdec_pkg::DR_IDCODE, aux_grant: 1'b0, aux_port: 5'h01},
    tdo:    1'b0,
    tdo_oe: 1'b0
  };

  tapdec_neg_s            neg;
  tapdec_neg_s            next_neg;
  tapdec_pos_s            pos;
  tapdec_pos_s            next_pos;
  tapdec_sys_s            sys;
  tapdec_sys_s            next_sys;
  tapdec_pkg::tapdec_op_t ir;
  tapdec_pkg::tapdec_sel_s ir_sel;
  logic                   ir_lsb;
  logic                   ack_tck;
  logic                   req_sys;
  logic                   dr_out;

  tapdec_ir u_ir (
    .i_tck        (i_tck),
    .i_trst       (i_trst),
    .i_tlr        (i_tlr),
    .i_capture_ir (i_capture_ir),
    .i_shift_ir   (i_shift_ir),
    .i_update_ir  (i_update_ir),
    .i_tdi        (i_tdi),
    .o_ir_lsb     (ir_lsb),
    .o_ir         (ir)
  );

  assign ir_sel = tapdec_pkg::decode_sel(ir); // R3 R11 R12 R13 R14 R15 R16

  // serial path select from the latched instruction only
  always_comb
  begin
    case (neg.sel.dr)
      tapdec_pkg::DR_IDCODE:     dr_out = i_tdo_idcode; // R1
      tapdec_pkg::DR_BSR:        dr_out = i_tdo_bsr; // R2
      tapdec_pkg::DR_UNLOCK_KEY: dr_out = i_tdo_unlock_key; // R5
      tapdec_pkg::DR_IFACE_CTRL: dr_out = i_tdo_iface_ctrl; // R8
      tapdec_pkg::DR_IFACE_PAD:  dr_out = i_tdo_iface_pad; // R9
      tapdec_pkg::DR_AUX:        dr_out = i_tdo_aux; // R10
      default:                   dr_out = pos.bypass; // R21
    endcase
  end

  always_comb
  begin
    next_neg.sel    = ir_sel;
    next_neg.tdo    = i_shift_ir ? ir_lsb : dr_out;
    next_neg.tdo_oe = i_shift_ir | i_shift_dr;
    if (i_tlr)
    begin
      next_neg = NEG_RESET;
    end
  end

  // tdo changes on the falling edge so the master samples it mid-bit
  always_ff @(negedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      neg <= NEG_RESET;
    else
      neg <= next_neg;
  end

  // bypass bit and the opcode handoff toward the system clock
  always_comb
  begin
    next_pos = pos;
    if (i_capture_dr)
    begin
      next_pos.bypass = 1'b0;
    end
    else if (i_shift_dr)
    begin
      next_pos.bypass = i_tdi;
    end
    // xfer only moves once the last word was acknowledged
    // a tap reset alone realigns itself after one spare exchange
    if ((pos.req == ack_tck) && (ir != pos.xfer))
    begin
      next_pos.xfer = ir;
      next_pos.req  = ~pos.req;
    end
  end

  always_ff @(posedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      pos <= '{bypass: 1'b0, xfer: tapdec_pkg::IR_RESET_VAL, req: 1'b0};
    else
      pos <= next_pos;
  end

  tapdec_sync u_req_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (pos.req),
    .o_q   (req_sys)
  );

  tapdec_sync u_ack_sync (
    .i_clk (i_tck),
    .i_rst (i_trst),
    .i_d   (sys.ack),
    .o_q   (ack_tck)
  );

  // xfer is stable while req and ack differ, so it is read directly
  always_comb
  begin
    next_sys    = sys;
    next_sys.fx = tapdec_pkg::decode_fx(sys.op); // R4 R6 R7
    if (req_sys != sys.ack)
    begin
      next_sys.op  = pos.xfer;
      next_sys.ack = ~sys.ack;
    end
    if (i_rst)
    begin
      next_sys = '{op: tapdec_pkg::IR_RESET_VAL, ack: 1'b0, fx: '0};
    end
  end

  always_ff @(posedge i_clk)
  begin
    sys <= next_sys;
  end

  assign o_tdo       = neg.tdo;
  assign o_tdo_oe    = neg.tdo_oe;
  assign o_sel       = neg.sel;
  assign o_ir        = ir;
  assign o_fx        = sys.fx;
  assign o_active_op = sys.op;

  a_idcode_path: assert property (@(negedge i_tck) disable iff (i_trst) // R1
    ir == tapdec_pkg::OP_IDCODE && !i_tlr |=> neg.sel.dr == tapdec_pkg::DR_IDCODE)
    else $error("identification code did not select id register");
  a_sample_pre_path: assert property (@(negedge i_tck) disable iff (i_trst) // R2
    ir == tapdec_pkg::OP_SAMPLE_PRE && !i_tlr |=> neg.sel.dr == tapdec_pkg::DR_BSR)
    else $error("sample preload did not select boundary scan");
  a_sample_path: assert property (@(negedge i_tck) disable iff (i_trst) // R3
    ir == tapdec_pkg::OP_SAMPLE && !i_tlr |=> neg.sel.dr == tapdec_pkg::DR_BSR)
    else $error("sample did not select boundary scan");
  a_sample_no_fx: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    sys.op == tapdec_pkg::OP_SAMPLE |=> o_fx == '0)
    else $error("sample disturbed functional operation");
  a_extest_fx: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    sys.op == tapdec_pkg::OP_EXTEST |=> o_fx.func_reset && o_fx.drive_preload
      && !o_fx.pins_highz)
    else $error("extest effects wrong");
  a_key_path: assert property (@(negedge i_tck) disable iff (i_trst) // R5
    ir == tapdec_pkg::OP_UNLOCK_KEY && !i_tlr |=> neg.sel.dr == tapdec_pkg::DR_UNLOCK_KEY)
    else $error("unlock key register not selected");
  a_highz_fx: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    sys.op == tapdec_pkg::OP_HIGHZ |=> o_fx.pins_highz && o_fx.func_reset
      && !o_fx.drive_preload)
    else $error("highz effects wrong");
  a_clamp_fx: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    sys.op == tapdec_pkg::OP_CLAMP |=> o_fx.drive_preload && o_fx.func_reset
      && !o_fx.pins_highz)
    else $error("clamp effects wrong");
  a_iface_ctrl_path: assert property (@(negedge i_tck) disable iff (i_trst) // R8
    ir == tapdec_pkg::OP_IFACE_CTRL && !i_tlr |=> neg.sel.dr == tapdec_pkg::DR_IFACE_CTRL)
    else $error("interface control register not selected");
  a_iface_pad_path: assert property (@(negedge i_tck) disable iff (i_trst) // R9
    ir == tapdec_pkg::OP_IFACE_PAD && !i_tlr |=> neg.sel.dr == tapdec_pkg::DR_IFACE_PAD)
    else $error("interface pad register not selected");
  a_aux_port_code: assert property (@(negedge i_tck) disable iff (i_trst) // R10
    neg.sel.aux_grant |-> neg.sel.aux_port == $past(ir[4:0])
      && $past(ir) >= tapdec_pkg::OP_AUX_LO && $past(ir) <= tapdec_pkg::OP_AUX_HI)
    else $error("aux grant outside range or wrong port");
  a_aux_named: assert property (@(negedge i_tck) disable iff (i_trst) // R12 R13 R14 R15
    !i_tlr && (ir == tapdec_pkg::OP_AUX_TRACE || ir == tapdec_pkg::OP_AUX_SECDBG
      || ir == tapdec_pkg::OP_AUX_SECCORE || ir == tapdec_pkg::OP_AUX_CORE0
      || ir == tapdec_pkg::OP_AUX_CORE1) |=> neg.sel.aux_grant)
    else $error("named aux controller not granted");
  a_reserved_bypass: assert property (@(negedge i_tck) disable iff (i_trst) // R11 R16 R21
    !i_tlr && (ir == tapdec_pkg::OP_FDBG_A || ir == tapdec_pkg::OP_FDBG_B
      || ir == tapdec_pkg::OP_FDBG_C || ir == tapdec_pkg::OP_AUX_LO
      || ir == tapdec_pkg::OP_AUX_RSV || ir == tapdec_pkg::OP_AUX_FTEST)
      |=> neg.sel.dr == tapdec_pkg::DR_BYPASS && !neg.sel.aux_grant)
    else $error("reserved code opened a function");
  a_tdo_oe_shift: assert property (@(negedge i_tck) disable iff (i_trst) // R18
    i_shift_ir && !i_tlr |=> o_tdo_oe && o_tdo == $past(ir_lsb))
    else $error("shift-ir output wrong");

  // effects of preload and reserved codes, the crossing, the reset state and the bypass and aux paths
  a_preload_no_fx: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    sys.op == tapdec_pkg::OP_SAMPLE_PRE |=> o_fx == '0)
    else $error("sample preload disturbed functional operation");
  a_reserved_no_fx: assert property (@(posedge i_clk) disable iff (i_rst) // R11 R16
    (sys.op == tapdec_pkg::OP_FDBG_A || sys.op == tapdec_pkg::OP_FDBG_B
      || sys.op == tapdec_pkg::OP_FDBG_C || sys.op == tapdec_pkg::OP_AUX_LO
      || sys.op == tapdec_pkg::OP_AUX_RSV || sys.op == tapdec_pkg::OP_AUX_FTEST)
      |=> o_fx == '0)
    else $error("reserved code drove a pin effect");
  a_op_handoff: assert property (@(posedge i_clk) disable iff (i_rst) // R17
    req_sys != sys.ack |=> o_active_op == $past(pos.xfer))
    else $error("crossed instruction differs from the sent word");
  a_tlr_sel_idcode: assert property (@(negedge i_tck) disable iff (i_trst) // R19
    i_tlr |=> neg.sel.dr == tapdec_pkg::DR_IDCODE && !neg.sel.aux_grant)
    else $error("test-logic-reset did not restore identification select");
  a_bypass_shift: assert property (@(negedge i_tck) disable iff (i_trst) // R21
    neg.sel.dr == tapdec_pkg::DR_BYPASS && i_shift_dr && !i_shift_ir && !i_tlr
      |=> o_tdo == $past(pos.bypass))
    else $error("bypass bit not on the serial output");
  a_aux_grant_dr: assert property (@(negedge i_tck) disable iff (i_trst) // R10
    neg.sel.aux_grant |-> neg.sel.dr == tapdec_pkg::DR_AUX)
    else $error("aux grant without aux serial path");

  c_extest_seen: cover property (@(posedge i_clk) disable iff (i_rst)
    sys.op == tapdec_pkg::OP_EXTEST ##2 o_fx.drive_preload);
  c_aux_grant: cover property (@(negedge i_tck) disable iff (i_trst)
    neg.sel.aux_grant);
  c_bypass_shift: cover property (@(negedge i_tck) disable iff (i_trst)
    neg.sel.dr == tapdec_pkg::DR_BYPASS && i_shift_dr);
  c_highz_seen: cover property (@(posedge i_clk) disable iff (i_rst)
    o_fx.pins_highz);
  c_tlr_return: cover property (@(negedge i_tck) disable iff (i_trst)
    i_tlr ##1 neg.sel.dr == tapdec_pkg::DR_IDCODE);

endmodule
`default_nettype wire

// ### test_tapdec_top.sv
// self-checking bench for the tap instruction decoder
`timescale 1ns/10ps
`default_nettype none
module test_tapdec_top;
  logic                    i_clk;
  logic                    i_rst;
  logic                    i_trst;
  logic                    tck;
  logic [5:0]              st;
  logic                    tdi;
  logic [5:0]              tsrc;
  logic                    o_tdo;
  logic                    o_tdo_oe;
  tapdec_pkg::tapdec_sel_s o_sel;
  tapdec_pkg::tapdec_op_t  o_ir;
  tapdec_pkg::tapdec_fx_s  o_fx;
  tapdec_pkg::tapdec_op_t  o_active_op;
  int                      num_errors;
  int                      checked;
  logic [31:0]             lfsr;

  tapdec_top u_tapdec_top (
    .i_clk            (i_clk),
    .i_rst            (i_rst),
    .i_tck            (tck),
    .i_trst           (i_trst),
    .i_tlr            (st[5]),
    .i_capture_ir     (st[4]),
    .i_shift_ir       (st[3]),
    .i_update_ir      (st[2]),
    .i_capture_dr     (st[1]),
    .i_shift_dr       (st[0]),
    .i_tdi            (tdi),
    .i_tdo_idcode     (tsrc[0]),
    .i_tdo_bsr        (tsrc[1]),
    .i_tdo_unlock_key (tsrc[2]),
    .i_tdo_iface_ctrl (tsrc[3]),
    .i_tdo_iface_pad  (tsrc[4]),
    .i_tdo_aux        (tsrc[5]),
    .o_tdo            (o_tdo),
    .o_tdo_oe         (o_tdo_oe),
    .o_sel            (o_sel),
    .o_ir             (o_ir),
    .o_fx             (o_fx),
    .o_active_op      (o_active_op)
  );

  tapdec_master u_tapdec_master (
    .o_tck    (tck),
    .o_st     (st),
    .o_tdi    (tdi),
    .i_tdo    (o_tdo),
    .i_tdo_oe (o_tdo_oe)
  );

  always #5 i_clk = ~i_clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // reference decode; aux port always follows the low code bits
  function automatic tapdec_pkg::tapdec_sel_s exp_sel(input int op);
    tapdec_pkg::tapdec_sel_s s;
    s.aux_grant = 1'b0;
    s.aux_port = op[4:0];
    case (op)
      1:       s.dr = tapdec_pkg::DR_IDCODE;
      2, 3, 4: s.dr = tapdec_pkg::DR_BSR;
      7:       s.dr = tapdec_pkg::DR_UNLOCK_KEY;
      14:      s.dr = tapdec_pkg::DR_IFACE_CTRL;
      15:      s.dr = tapdec_pkg::DR_IFACE_PAD;
      33, 38, 39, 40, 41:
      begin
        s.dr = tapdec_pkg::DR_AUX;
        s.aux_grant = 1'b1;
      end
      default: s.dr = tapdec_pkg::DR_BYPASS;
    endcase
    return s;
  endfunction

  // {func_reset, pins_highz, drive_preload}
  function automatic tapdec_pkg::tapdec_fx_s exp_fx(input int op);
    tapdec_pkg::tapdec_fx_s f;
    f = '0;
    if (op == 4 || op == 12)
      f = 3'b101;
    if (op == 9)
      f = 3'b110;
    return f;
  endfunction

  task automatic note(input string nm, input logic ok, input logic [15:0] e,
                      input logic [15:0] g);
    checked++;
    if (!ok)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_op(input string nm, input tapdec_pkg::tapdec_op_t e,
                        input tapdec_pkg::tapdec_op_t g);
    note(nm, g === e, 16'(e), 16'(g));
  endtask

  task automatic chk_sel(input string nm, input tapdec_pkg::tapdec_sel_s e,
                         input tapdec_pkg::tapdec_sel_s g);
    note(nm, g === e, 16'(e), 16'(g));
  endtask

  task automatic chk_fx(input string nm, input tapdec_pkg::tapdec_fx_s e,
                        input tapdec_pkg::tapdec_fx_s g);
    note(nm, g === e, 16'(e), 16'(g));
  endtask

  task automatic chk_bits(input string nm, input logic [7:0] e, input logic [7:0] g);
    note(nm, g === e, 16'(e), 16'(g));
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // both resets together keep the crossing handshake aligned; tck runs for its sync reset
  task automatic do_reset();
    #1 i_trst = 1'b1;
    #2;
    chk_op("ir async reset", 6'h01, o_ir);
    @(posedge i_clk);
    #1 i_rst = 1'b1;
    fork
      repeat (10) @(posedge i_clk);
      u_tapdec_master.idle(4);
    join
    #1 i_rst = 1'b0;
    i_trst = 1'b0;
  endtask

  task automatic run_op(input int op);
    logic [5:0]              cap;
    logic [7:0]              din;
    logic [7:0]              dout;
    logic [7:0]              exp;
    tapdec_pkg::tapdec_sel_s s;
    s = exp_sel(op);
    u_tapdec_master.load_ir(op[5:0], 1'b1, cap);
    chk_op("ir capture readout", 6'h01, cap);
    chk_op("latched ir", op[5:0], o_ir);
    chk_sel("serial path select", s, o_sel);
    chk_bits("tdo_oe idle", 8'h00, {7'h0, o_tdo_oe});
    lfsr = lfsr_next(lfsr);
    tsrc = lfsr[5:0];
    din = lfsr[15:8];
    if (s.dr == tapdec_pkg::DR_BYPASS)
      exp = {din[6:0], 1'b0};
    else
      exp = {8{tsrc[int'(s.dr) - 1]}};
    u_tapdec_master.scan_dr(din, dout);
    chk_bits("dr serial out", exp, dout);
    chk_op("active op", op[5:0], o_active_op);
    chk_fx("pin effects", exp_fx(op), o_fx);
  endtask

  initial
  begin
    logic [5:0] cap;
    int         ops[$];
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_trst = 1'b0;
    tsrc = '0;
    num_errors = 0;
    checked = 0;
    lfsr = 32'h98bd9eea;
    do_reset();
    chk_op("active op reset", 6'h01, o_active_op);
    chk_fx("fx reset", 3'b000, o_fx);
    $display("test reset done");
    // only codes with a listed meaning; reserved ones probe the bypass fallback
    ops = {1, 2, 3, 4, 5, 6, 7, 9, 10, 12, 14, 15, 32, 33, 34, 37, 38, 39, 40, 41};
    foreach (ops[i])
      run_op(ops[i]);
    chk_bits("tdo_oe in shift", 8'h01, {7'h0, u_tapdec_master.oe_all});
    $display("test opcode sweep done");
    u_tapdec_master.load_ir(6'h09, 1'b1, cap);
    u_tapdec_master.load_ir(6'h04, 1'b0, cap);
    chk_op("ir held without update", 6'h09, o_ir);
    chk_fx("effects held", 3'b110, o_fx);
    $display("test shift without update done");
    u_tapdec_master.reset_tap();
    chk_op("ir after sync reset state", 6'h01, o_ir);
    chk_sel("select after reset state", exp_sel(1), o_sel);
    chk_fx("effects after reset state", 3'b000, o_fx);
    $display("test sync tap reset done");
    u_tapdec_master.load_ir(6'h0c, 1'b1, cap);
    chk_fx("clamp effects", 3'b101, o_fx);
    do_reset();
    chk_op("active op after async reset", 6'h01, o_active_op);
    $display("test async tap reset done");
    final_report();
  end

  // all tests take about 10 us; a generous margin beyond that means a hang
  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
